// file: dv/opcode_store.sv
`timescale 1ns/1ps
module opcode_store (
	input  wire [5:0] idx,
	output wire [7:0] opc
);
	// relative column, then the call, then a hole in the map
	assign opc = (idx < 6'd16) ? {4'h2, idx[3:0]} : (idx == 6'd16) ? 8'hAD : 8'h41;
endmodule

// file: dv/rmw_and_branch_decoder_asserts.sv
`timescale 1ns/1ps
module decoder_checker (
	input wire        hclk,
	input wire        hresetn,
	input wire        hsel,
	input wire [31:0] haddr,
	input wire [1:0]  htrans,
	input wire        hwrite,
	input wire [31:0] hwdata,
	input wire        hready,
	input wire        hreadyout,
	input wire        hresp,
	input wire        irq_pin,
	input wire        exec_busy,
	input wire        branch_taken
);
	reg        op_wr_ff;
	wire       go = op_wr_ff & hready & !exec_busy;
	wire [7:0] opc = hwdata[7:0];
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			op_wr_ff <= 1'b0;
		else if (hready)
			op_wr_ff <= hsel & htrans[1] & hwrite & (haddr[7:2] == 6'h00);
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_inh_len: assert property (go && opc == 8'h4C |=> exec_busy [*3] ##1 !exec_busy)
		else $error("inherent busy length wrong");
	a_ix1_len: assert property (go && opc == 8'h6C |=> exec_busy [*6] ##1 !exec_busy)
		else $error("offset indexed busy length wrong");
	a_rotl_dir: assert property (go && opc == 8'h39 |=> exec_busy [*5] ##1 !exec_busy)
		else $error("direct rotate busy length wrong");
	a_test_dir: assert property (go && opc == 8'h3D |=> exec_busy [*4] ##1 !exec_busy)
		else $error("direct test busy length wrong");
	a_rel_len: assert property (go && opc[7:4] == 4'h2 |=> exec_busy [*3] ##1 !exec_busy)
		else $error("relative busy length wrong");
	a_call_len: assert property (go && opc == 8'hAD |=> exec_busy [*6] ##1 !exec_busy)
		else $error("call busy length wrong");
	a_always_tkn: assert property (go && opc == 8'h20 |=> branch_taken)
		else $error("branch always not taken");
	a_never_tkn: assert property (go && opc == 8'h21 |=> !branch_taken)
		else $error("branch never taken");
	a_irq_high: assert property (go && opc == 8'h2F && $past(hresetn, 2) && $past(irq_pin)
		&& $past(irq_pin, 2) |=> branch_taken) else $error("line high branch wrong");
	a_irq_low: assert property (go && opc == 8'h2E && $past(hresetn, 2) && !$past(irq_pin)
		&& !$past(irq_pin, 2) |=> branch_taken) else $error("line low branch wrong");
	a_read_wait: assert property (hsel && htrans[1] && hready && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	c_call: cover property (go && opc == 8'hAD);
	c_busy_drop: cover property (op_wr_ff && hready && exec_busy);
	c_rel: cover property (go && opc[7:4] == 4'h2);
endmodule
bind rmw_and_branch_decoder decoder_checker chk (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
	.hwdata, .hready, .hreadyout, .hresp, .irq_pin, .exec_busy, .branch_taken);

// file: dv/rmw_and_branch_decoder_tb.sv
`timescale 1ns/1ps
`include "rmw_branch_map.vh"
module rmw_and_branch_decoder_tb;
	reg         hclk;
	reg         hresetn;
	reg         hsel;
	reg  [31:0] haddr;
	reg  [1:0]  htrans;
	reg         hwrite;
	reg  [31:0] hwdata;
	reg         irq_pin;
	reg  [5:0]  idx;
	reg  [31:0] rd;
	wire        hreadyout;
	wire [31:0] hrdata;
	wire        exec_busy;
	wire        branch_taken;
	wire [7:0]  opc;
	integer     num_errors;
	integer     cmp_count;

	rmw_and_branch_decoder uut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
		.hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .irq_pin, .exec_busy,
		.branch_taken);
	opcode_store prog (.idx, .opc);

	initial begin
		hclk = 1'b0;
		forever #20 hclk = ~hclk;
	end

	task complete_run;
		$display("errors %0d compares %0d", num_errors, cmp_count);
		if (num_errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task chk(input [31:0] got, input [31:0] exp);
		cmp_count = cmp_count + 1;
		if (got !== exp) begin
			num_errors = num_errors + 1;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task until_ready;
		integer n;
		reg     rdy;
		n = 0;
		rdy = 1'b0;
		while (!rdy) begin
			@(negedge hclk);
			rdy = (hreadyout === 1'b1);
			rd = hrdata;
			@(posedge hclk);
			n = n + 1;
			if (n > 40) begin
				num_errors = num_errors + 1;
				complete_run;
			end
		end
	endtask

	task bus(input w, input [31:0] a, input [31:0] d);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= a;
		hwrite <= w;
		until_ready;
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		until_ready;
	endtask

	task idle;
		integer n;
		n = 0;
		@(negedge hclk);
		while (exec_busy !== 1'b0) begin
			@(negedge hclk);
			n = n + 1;
			if (n > 40) begin
				num_errors = num_errors + 1;
				complete_run;
			end
		end
	endtask

	task run_op(input [7:0] op);
		bus(1'b1, `OFS_OPCODE, {24'h0, op});
		idle;
		bus(1'b0, `OFS_DECODE, 32'h0);
	endtask

	function [31:0] dexp(input [1:0] gr, input [3:0] op, input [2:0] md, input [1:0] by,
		input [3:0] cy);
		dexp = {12'h000, cy, 2'b00, by, 1'b0, md, op, gr, 2'b11};
	endfunction

	task t_misc;
		bus(1'b0, `OFS_FLAGS, 32'h0);
		chk(rd, 32'h0000_0008);
		bus(1'b0, 32'h0000_000C, 32'h0);
		chk(rd, 32'h0);
		idx = 6'd16;
		@(negedge hclk);
		run_op(opc);
		chk(rd & 32'h001F_37FF, dexp(2'h3, 4'hD, 3'h5, 2'h2, 4'h6) | 32'h0010_0000);
		run_op(8'h41);
		chk(rd & 32'h000F_0003, 32'h0000_0001);
		bus(1'b1, `OFS_OPCODE, 32'h3C);
		run_op(8'h4C);
		chk(rd & 32'h000F_37FF, dexp(2'h1, 4'hC, 3'h2, 2'h2, 4'h5));
	endtask

	task t_rmw;
		integer     i;
		integer     c;
		reg [43:0]  ops;
		reg [3:0]   nb;
		reg [3:0]   cy;
		reg [2:0]   md;
		ops = 44'h03467_89ACDF;
		for (i = 0; i < 11; i = i + 1) begin
			for (c = 3; c < 8; c = c + 1) begin
				nb = ops[4 * i +: 4];
				run_op({c[3:0], nb});
				md = (c == 3) ? 3'h2 : (c == 4) ? 3'h0 : (c == 5) ? 3'h1 : (c == 6) ? 3'h4 : 3'h3;
				cy = (c == 4 || c == 5) ? 4'h3 : (c == 6) ? 4'h6 : 4'h5;
				if (nb == 4'hD && cy != 4'h3)
					cy = cy - 4'h1;
				chk(rd & 32'h000F_37FF, dexp(2'h1, nb, md, (c == 3 || c == 6) ? 2'h2 : 2'h1, cy));
			end
		end
	endtask

	task t_branch;
		integer     k;
		integer     j;
		reg [4:0]   f;
		reg [15:0]  v;
		for (k = 0; k < 4; k = k + 1) begin
			f = (k == 0) ? 5'h00 : (k == 1) ? 5'h01 : (k == 2) ? 5'h02 : 5'h1C;
			irq_pin <= k[0];
			bus(1'b1, `OFS_FLAGS, {27'h0, f});
			v = {k[0], ~k[0], f[3], ~f[3], f[2], ~f[2], f[4], ~f[4], f[1], ~f[1], f[0], ~f[0],
				f[0] | f[1], ~(f[0] | f[1]), 2'b01};
			for (j = 0; j < 16; j = j + 1) begin
				idx = j[5:0];
				@(negedge hclk);
				run_op(opc);
				chk(rd & 32'h001F_37FF, dexp(2'h2, j[3:0], 3'h5, 2'h2, 4'h3) | {11'h0, v[j], 20'h0});
				chk({31'h0, branch_taken}, {31'h0, v[j]});
			end
		end
	endtask

	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hwdata = 32'h0;
		irq_pin = 1'b1;
		idx = 6'h00;
		num_errors = 0;
		cmp_count = 0;
		repeat (6) @(posedge hclk);
		hresetn <= 1'b1;
		t_misc;
		t_rmw;
		t_branch;
		complete_run;
	end
endmodule

// file: hdl/opcode_classifier.v
`timescale 1ns/1ps
`include "rmw_branch_map.vh"

module opcode_classifier (
	input  wire [7:0] opcode,
	output reg        legal,
	output reg  [1:0] group,
	output reg  [2:0] mode,
	output reg  [1:0] bytes,
	output reg  [3:0] cycles
);

	wire [3:0] col;
	wire [3:0] low;
	reg        op_ok;
	reg        is_test;

	assign col = opcode[7:4];
	assign low = opcode[3:0];

	always @* begin
		op_ok   = 1'b0;
		is_test = (low == `OP_TEST);
		case (low)
			`OP_TWOS_INVERT, `OP_ONES_INVERT, `OP_SHR_LOGICAL,
			`OP_ROTATE_RIGHT, `OP_SHR_SIGNED, `OP_SHL_LOGICAL,
			`OP_ROTATE_LEFT, `OP_MINUS_ONE, `OP_PLUS_ONE,
			`OP_TEST, `OP_ZERO_FILL: op_ok = 1'b1;
			default: op_ok = 1'b0;
		endcase
	end

	always @* begin
		legal  = 1'b0;
		group  = `GRP_NONE;
		mode   = `MODE_INH_A;
		bytes  = 2'h0;
		cycles = 4'h0;
		if (opcode == `OPC_CALL) begin
			legal  = 1'b1;
			group  = `GRP_CALL;
			mode   = `MODE_REL;
			bytes  = `BYTES_TWO;
			cycles = `CYC_CALL;
		end else if (col == `COL_REL) begin
			legal  = 1'b1;
			group  = `GRP_REL;
			mode   = `MODE_REL;
			bytes  = `BYTES_TWO;
			cycles = `CYC_REL;
		end else if (op_ok) begin
			group = `GRP_RMW;
			legal = 1'b1;
			case (col)
				`COL_INH_A: begin
					mode   = `MODE_INH_A;
					bytes  = `BYTES_ONE;
					cycles = `CYC_INH;
				end
				`COL_INH_X: begin
					mode   = `MODE_INH_X;
					bytes  = `BYTES_ONE;
					cycles = `CYC_INH;
				end
				`COL_DIR: begin
					mode   = `MODE_DIR;
					bytes  = `BYTES_TWO;
					cycles = is_test ? `CYC_DIR - 4'h1 : `CYC_DIR;
				end
				`COL_IX: begin
					mode   = `MODE_IX;
					bytes  = `BYTES_ONE;
					cycles = is_test ? `CYC_IX - 4'h1 : `CYC_IX;
				end
				`COL_IX1: begin
					mode   = `MODE_IX1;
					bytes  = `BYTES_TWO;
					cycles = is_test ? `CYC_IX1 - 4'h1 : `CYC_IX1;
				end
				default: begin
					legal = 1'b0;
					group = `GRP_NONE;
				end
			endcase
		end
	end

endmodule

// file: hdl/rmw_and_branch_decoder.v
// Behaviour
// - six addressing modes with fixed lengths, cycles; test D takes one cycle less in 3x, 6x, 7x, call AD takes 6
// - 49,59,39,79,69 rotate left through carry
// - 23 branches when carry or zero set
// - 24 branches when carry clear
// - 25 branches when carry set
// - 26 branches when zero clear
// - 28 branches when half carry clear
// - 29 branches when half carry set
// - 2C branches when interrupt mask clear
// - 2D branches when interrupt mask set
// - 2E branches when interrupt line low
// - 2F branches when interrupt line high
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "rmw_branch_map.vh"

module rmw_and_branch_decoder (
	input  wire        hclk,
	input  wire        hresetn,
	input  wire        hsel,
	input  wire [31:0] haddr,
	input  wire [1:0]  htrans,
	input  wire        hwrite,
	input  wire [2:0]  hsize,
	input  wire [31:0] hwdata,
	input  wire        hready,
	output wire        hreadyout,
	output wire        hresp,
	output reg  [31:0] hrdata,
	input  wire        irq_pin,
	output reg         exec_busy,
	output reg         branch_taken
);

	// bus phase tracking
	reg        wr_pend_ff;
	reg        rd_wait_ff;
	reg  [7:0] addr_ff;
	wire       take;
	wire       nxt_wr_pend;
	wire       nxt_rd_wait;

	// interrupt pin synchroniser
	reg        irq_meta_ff;
	reg        irq_sync_ff;

	// software visible state
	reg  [7:0] opcode_ff;
	reg  [`FLG_W-1:0] flags_ff;
	reg        valid_ff;
	reg        legal_ff;
	reg  [1:0] group_ff;
	reg  [3:0] op_ff;
	reg  [2:0] mode_ff;
	reg  [1:0] bytes_ff;
	reg  [3:0] cycles_ff;
	reg        taken_ff;
	reg  [3:0] cyc_left_ff;

	// decode of the incoming opcode
	wire       cls_legal;
	wire [1:0] cls_group;
	wire [2:0] cls_mode;
	wire [1:0] cls_bytes;
	wire [3:0] cls_cycles;
	reg        cond_met;
	reg  [3:0] nxt_cyc_left;
	reg  [31:0] rd_mux;
	wire [7:0] wr_opcode;
	wire       wr_op_hit;
	wire       wr_flag_hit;
	wire       load;
	wire       flag_c;
	wire       flag_z;
	wire       flag_n;
	wire       flag_i;
	wire       flag_h;
	genvar     gi;

	localparam [`FLG_W-1:0] flag_rst_val = `FLAGS_RST;

	assign hreadyout = ~rd_wait_ff;
	assign hresp     = 1'b0;

	assign take        = hsel & htrans[1] & hready;
	assign nxt_wr_pend = take & hwrite;
	assign nxt_rd_wait = take & ~hwrite;

	assign wr_op_hit   = wr_pend_ff & (addr_ff == `OFS_OPCODE);
	assign wr_flag_hit = wr_pend_ff & (addr_ff == `OFS_FLAGS);
	assign wr_opcode   = hwdata[7:0];

	// opcode writes are ignored while an instruction is still running
	assign load = wr_op_hit & (cyc_left_ff == 4'h0);

	assign flag_c = flags_ff[`FLG_C];
	assign flag_z = flags_ff[`FLG_Z];
	assign flag_n = flags_ff[`FLG_N];
	assign flag_i = flags_ff[`FLG_I];
	assign flag_h = flags_ff[`FLG_H];

	opcode_classifier u_classifier (
		.opcode (wr_opcode),
		.legal  (cls_legal),
		.group  (cls_group),
		.mode   (cls_mode),
		.bytes  (cls_bytes),
		.cycles (cls_cycles)
	);

	// branch condition on flags and the synchronised interrupt line
	always @* begin
		cond_met = 1'b0;
		if (cls_group == `GRP_CALL) begin
			cond_met = 1'b1;
		end else if (cls_group == `GRP_REL) begin
			case (wr_opcode[3:0])
				`BR_ALWAYS: begin
					cond_met = 1'b1;
				end
				`BR_NEVER: begin
					cond_met = 1'b0;
				end
				`BR_HIGHER: begin
					cond_met = ~(flag_c | flag_z);
				end
				`BR_LOWER_SAME: begin
					cond_met = flag_c | flag_z;
				end
				`BR_CARRY_CLEAR: begin
					cond_met = ~flag_c;
				end
				`BR_CARRY_SET: begin
					cond_met = flag_c;
				end
				`BR_NOT_EQUAL: begin
					cond_met = ~flag_z;
				end
				`BR_EQUAL: begin
					cond_met = flag_z;
				end
				`BR_HALF_CLEAR: begin
					cond_met = ~flag_h;
				end
				`BR_HALF_SET: begin
					cond_met = flag_h;
				end
				`BR_PLUS: begin
					cond_met = ~flag_n;
				end
				`BR_MINUS: begin
					cond_met = flag_n;
				end
				`BR_MASK_CLEAR: begin
					cond_met = ~flag_i;
				end
				`BR_MASK_SET: begin
					cond_met = flag_i;
				end
				`BR_IRQ_LOW: begin
					cond_met = ~irq_sync_ff;
				end
				`BR_IRQ_HIGH: begin
					cond_met = irq_sync_ff;
				end
				default: begin
					cond_met = 1'b0;
				end
			endcase
		end
	end

	// instruction cycle counter
	always @* begin
		nxt_cyc_left = cyc_left_ff;
		if (load) begin
			nxt_cyc_left = cls_legal ? cls_cycles : 4'h0;
		end else if (cyc_left_ff != 4'h0) begin
			nxt_cyc_left = cyc_left_ff - 4'h1;
		end
	end

	// register read mux
	always @* begin
		rd_mux = 32'h0000_0000;
		if (addr_ff == `OFS_OPCODE) begin
			rd_mux[7:0] = opcode_ff;
		end else if (addr_ff == `OFS_FLAGS) begin
			rd_mux[`FLG_W-1:0] = flags_ff;
		end else if (addr_ff == `OFS_DECODE) begin
			rd_mux[`DCD_VALID]                  = valid_ff;
			rd_mux[`DCD_LEGAL]                  = legal_ff;
			rd_mux[`DCD_GRP_LO+1:`DCD_GRP_LO]   = group_ff;
			rd_mux[`DCD_OP_LO+3:`DCD_OP_LO]     = op_ff;
			rd_mux[`DCD_MODE_LO+2:`DCD_MODE_LO] = mode_ff;
			rd_mux[`DCD_BYTES_LO+1:`DCD_BYTES_LO] = bytes_ff;
			rd_mux[`DCD_CYC_LO+3:`DCD_CYC_LO]   = cycles_ff;
			rd_mux[`DCD_TAKEN]                  = taken_ff;
			rd_mux[`DCD_BUSY]                   = exec_busy;
		end
	end

	// bus phase and transfer address
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_ff <= 1'b0;
			rd_wait_ff <= 1'b0;
			addr_ff    <= 8'h00;
		end else begin
			wr_pend_ff <= nxt_wr_pend;
			rd_wait_ff <= nxt_rd_wait;
			if (take) begin
				addr_ff <= {haddr[7:2], 2'b00};
			end
		end
	end

	// read data, loaded in the wait cycle, held until the next read
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrdata <= 32'h0000_0000;
		end else if (rd_wait_ff) begin
			hrdata <= rd_mux;
		end
	end

	// two flip-flops before the interrupt line is used
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			irq_meta_ff <= 1'b1;
			irq_sync_ff <= 1'b1;
		end else begin
			irq_meta_ff <= irq_pin;
			irq_sync_ff <= irq_meta_ff;
		end
	end

	// flags register, one flop per flag
	generate
		for (gi = 0; gi < `FLG_W; gi = gi + 1) begin : g_flag
			always @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					flags_ff[gi] <= flag_rst_val[gi];
				end else if (wr_flag_hit) begin
					flags_ff[gi] <= hwdata[gi];
				end
			end
		end
	endgenerate

	// latched decode result
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			opcode_ff    <= 8'h00;
			valid_ff     <= 1'b0;
			legal_ff     <= 1'b0;
			group_ff     <= `GRP_NONE;
			op_ff        <= 4'h0;
			mode_ff      <= `MODE_INH_A;
			bytes_ff     <= 2'h0;
			cycles_ff    <= 4'h0;
			taken_ff     <= 1'b0;
		end else if (load) begin
			opcode_ff    <= wr_opcode;
			valid_ff     <= 1'b1;
			legal_ff     <= cls_legal;
			group_ff     <= cls_group;
			// low nibble names the operation; 9 is rotate left through carry
			op_ff        <= wr_opcode[3:0];
			mode_ff      <= cls_mode;
			bytes_ff     <= cls_bytes;
			cycles_ff    <= cls_cycles;
			taken_ff     <= cond_met;
		end
	end

	// taken output, follows accepted opcodes only
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			branch_taken <= 1'b0;
		end else if (load) begin
			branch_taken <= cond_met;
		end
	end

	// execution timing
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cyc_left_ff <= 4'h0;
		end else begin
			cyc_left_ff <= nxt_cyc_left;
		end
	end

	// busy flag, high while the counter runs
	always @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			exec_busy <= 1'b0;
		end else begin
			exec_busy <= (nxt_cyc_left != 4'h0);
		end
	end

endmodule

// file: hdl/rmw_branch_map.vh
`ifndef RMW_BRANCH_MAP_VH
`define RMW_BRANCH_MAP_VH

// register byte offsets
`define OFS_OPCODE        8'h00
`define OFS_FLAGS         8'h04
`define OFS_DECODE        8'h08

// flags register fields
`define FLG_C             0
`define FLG_Z             1
`define FLG_N             2
`define FLG_I             3
`define FLG_H             4
`define FLG_W             5
`define FLAGS_RST         5'h08

// decode register fields
`define DCD_VALID         0
`define DCD_LEGAL         1
`define DCD_GRP_LO        2
`define DCD_OP_LO         4
`define DCD_MODE_LO       8
`define DCD_BYTES_LO      12
`define DCD_CYC_LO        16
`define DCD_TAKEN         20
`define DCD_BUSY          24

// instruction groups
`define GRP_NONE          2'h0
`define GRP_RMW           2'h1
`define GRP_REL           2'h2
`define GRP_CALL          2'h3

// addressing modes
`define MODE_INH_A        3'h0
`define MODE_INH_X        3'h1
`define MODE_DIR          3'h2
`define MODE_IX           3'h3
`define MODE_IX1          3'h4
`define MODE_REL          3'h5

// opcode columns
`define COL_DIR           4'h3
`define COL_INH_A         4'h4
`define COL_INH_X         4'h5
`define COL_IX1           4'h6
`define COL_IX            4'h7
`define COL_REL           4'h2
`define OPC_CALL          8'hAD

// read-modify-write operation nibbles
`define OP_TWOS_INVERT    4'h0
`define OP_ONES_INVERT    4'h3
`define OP_SHR_LOGICAL    4'h4
`define OP_ROTATE_RIGHT   4'h6
`define OP_SHR_SIGNED     4'h7
`define OP_SHL_LOGICAL    4'h8
`define OP_ROTATE_LEFT    4'h9
`define OP_MINUS_ONE      4'hA
`define OP_PLUS_ONE       4'hC
`define OP_TEST           4'hD
`define OP_ZERO_FILL      4'hF

// branch conditions (low nibble of column 2)
`define BR_ALWAYS         4'h0
`define BR_NEVER          4'h1
`define BR_HIGHER         4'h2
`define BR_LOWER_SAME     4'h3
`define BR_CARRY_CLEAR    4'h4
`define BR_CARRY_SET      4'h5
`define BR_NOT_EQUAL      4'h6
`define BR_EQUAL          4'h7
`define BR_HALF_CLEAR     4'h8
`define BR_HALF_SET       4'h9
`define BR_PLUS           4'hA
`define BR_MINUS          4'hB
`define BR_MASK_CLEAR     4'hC
`define BR_MASK_SET       4'hD
`define BR_IRQ_LOW        4'hE
`define BR_IRQ_HIGH       4'hF

// lengths and cycle counts
`define BYTES_ONE         2'h1
`define BYTES_TWO         2'h2
`define CYC_INH           4'h3
`define CYC_DIR           4'h5
`define CYC_IX            4'h5
`define CYC_IX1           4'h6
`define CYC_REL           4'h3
`define CYC_CALL          4'h6

`endif
